/* include/iox_pkg.sv */
/*
  Shared constants and types of the I/O expander target block.
  Assumes a single 25 MHz clock and a synchronous active-high system reset.
*/
package iox_pkg;

  localparam int PORT_W = 8;

  // Target addresses chosen by the select pin
  localparam logic [6:0] ADDR_SEL_LOW = 7'h20;
  localparam logic [6:0] ADDR_SEL_HIGH = 7'h21;

  // Command values selecting a byte register
  localparam logic [1:0] CMD_INPUT = 2'h0;
  localparam logic [1:0] CMD_OUTPUT = 2'h1;
  localparam logic [1:0] CMD_POLARITY = 2'h2;
  localparam logic [1:0] CMD_CONFIG = 2'h3;

  // Values after reset
  localparam logic [7:0] RST_OUTPUT = 8'hff;
  localparam logic [7:0] RST_POLARITY = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'hff;
  localparam logic [1:0] RST_CMD = 2'h0;

  // Bit count at which a byte is complete
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Number of synchroniser stages on every pin input
  localparam int SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_RX = 3'b011,
    ST_RACK = 3'b100,
    ST_TX = 3'b101,
    ST_TACK = 3'b110
  } iox_state_t;

  // Pin inputs that cross into the clock domain together
  typedef struct packed {
    logic rstPinN;
    logic addrSel;
    logic scl;
    logic sda;
    logic [7:0] port;
  } iox_pins_t;

endpackage : iox_pkg

/* rtl/iox_expander.sv */
/*
  Two-wire target logic of an 8-bit I/O expander with change alert.
  Assumes bus pins, port pins and the reset pin are asynchronous to mclk,
  and external pull-ups on SDA and the alert line.
*/
//
// What this block does
// - Reset pin low forces all registers and bus state to defaults.
// - Port pins follow the registers only while the reset pin is high; while it is low they take reset values.
// - Any edge moving an input-configured pin off its value at last clearing asserts the alert.
// - Alert releases when changed inputs return to values at last clearing.
// - Reading the alerting port clears the alert at its ack bit rising SCL.
// - Input change during the clearing ack pulse may be lost.
// - After clearing, the first later input change asserts the alert again.
// - Transfers to other targets leave alert state untouched.
// - Output-configured pins never raise the alert.
// - Switching a pin to input may raise a spurious alert.
// - Alert is active-low open drain, driven low only when asserted.
// - Any number of data bytes accepted after the command byte.
// - Read phase returns register selected by latest command byte.
// - Each data byte is captured on rising edge of its ack clock.
// - Stop may end a transfer; data captured at latest ack stays.
// - With input port selected, reads may follow the address directly.
// - Respond to 0x20 with select pin low, 0x21 with it high.
// - Commands 0..3 select input, output, polarity, configuration; input unwritable.
// - Configuration bit 1 makes pin input, 0 makes it output.
// - Polarity bit inverts the reported input value of its pin.
`timescale 1ns/1ps
module iox_expander (
  input wire logic mclk, // 25 MHz system clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic rstPinN, // Reset pin, active low, asynchronous
  input wire logic addrSel, // Address select pin
  input wire logic scl, // Bus clock from controller
  input wire logic sdaIn, // Bus data level
  output logic sdaOut, // Bus data drive value, always low
  output logic sdaOe, // Bus data pull-down enable
  input wire logic [7:0] portIn, // Port pin levels
  output logic [7:0] portOut, // Port pin drive values
  output logic [7:0] portOe, // Port pin drive enables
  output logic alertOutN, // Alert drive value, always low
  output logic alertOe // Alert pull-down enable
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and reset

  iox_pkg::iox_pins_t pinsAsync;
  iox_pkg::iox_pins_t pinsSync;
  iox_pkg::iox_pins_t pinsRstVal;
  logic rstInt;

  assign pinsAsync = '{rstPinN: rstPinN, addrSel: addrSel, scl: scl, sda: sdaIn, port: portIn};
  assign pinsRstVal = '{rstPinN: 1'b1, addrSel: 1'b0, scl: 1'b1, sda: 1'b1, port: 8'h00};

  iox_sync #(
    .WIDTH($bits(iox_pkg::iox_pins_t))
  ) u_sync (
    .mclk(mclk),
    .asyncIn(pinsAsync),
    .resetVal(pinsRstVal),
    .rst(rst),
    .syncOut(pinsSync)
  );

  // Reset pin acts as long as it is low
  assign rstInt = rst | ~pinsSync.rstPinN;

  //////////////////////////////////////////////////////////////////////////////
  // Bus condition detection

  logic sclPrev_q;
  logic sdaPrev_q;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;

  always_ff @(posedge mclk) begin
    if (rstInt) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclPrev_q <= pinsSync.scl;
      sdaPrev_q <= pinsSync.sda;
    end
  end

  assign sclRise = pinsSync.scl & ~sclPrev_q;
  assign sclFall = ~pinsSync.scl & sclPrev_q;
  assign startDet = pinsSync.scl & sclPrev_q & sdaPrev_q & ~pinsSync.sda;
  assign stopDet = pinsSync.scl & sclPrev_q & ~sdaPrev_q & pinsSync.sda;

  //////////////////////////////////////////////////////////////////////////////
  // Register read decode

  logic [7:0] out_q;
  logic [7:0] pol_q;
  logic [7:0] cfg_q;
  logic [1:0] cmd_q;
  logic [7:0] inputVal;

  assign inputVal = pinsSync.port ^ pol_q;

  function automatic logic [7:0] regRead(input logic [1:0] sel, input logic [7:0] inV,
                                        input logic [7:0] outV, input logic [7:0] polV,
                                        input logic [7:0] cfgV);
    case (sel)
      iox_pkg::CMD_INPUT: regRead = inV;
      iox_pkg::CMD_OUTPUT: regRead = outV;
      iox_pkg::CMD_POLARITY: regRead = polV;
      default: regRead = cfgV;
    endcase
  endfunction : regRead

  //////////////////////////////////////////////////////////////////////////////
  // Bus state machine

  iox_pkg::iox_state_t state_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic rw_q;
  logic cmdPend_q;
  logic ackOk_q;
  logic [6:0] ownAddr;
  logic [7:0] rdVal;

  assign ownAddr = pinsSync.addrSel ? iox_pkg::ADDR_SEL_HIGH : iox_pkg::ADDR_SEL_LOW;
  assign rdVal = regRead(cmd_q, inputVal, out_q, pol_q, cfg_q);

  always_ff @(posedge mclk) begin
    if (rstInt) begin
      state_q <= iox_pkg::ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      cmdPend_q <= 1'b0;
      ackOk_q <= 1'b0;
      sdaOe <= 1'b0;
    end else if (startDet) begin
      state_q <= iox_pkg::ST_ADDR;
      bitCnt_q <= 4'h0;
      sdaOe <= 1'b0;
    end else if (stopDet) begin
      state_q <= iox_pkg::ST_IDLE;
      sdaOe <= 1'b0;
    end else begin
      case (state_q)
        iox_pkg::ST_ADDR, iox_pkg::ST_RX: begin
          if (sclRise && bitCnt_q != iox_pkg::BYTE_BITS) begin
            shift_q <= {shift_q[6:0], pinsSync.sda};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == iox_pkg::BYTE_BITS) begin
            bitCnt_q <= 4'h0;
            if (state_q == iox_pkg::ST_RX) begin
              sdaOe <= 1'b1;
              state_q <= iox_pkg::ST_RACK;
            end else if (shift_q[7:1] == ownAddr) begin
              sdaOe <= 1'b1;
              rw_q <= shift_q[0];
              state_q <= iox_pkg::ST_AACK;
            end else begin
              state_q <= iox_pkg::ST_IDLE;
            end
          end
        end
        iox_pkg::ST_AACK: begin
          if (sclFall) begin
            if (rw_q) begin
              tx_q <= rdVal;
              sdaOe <= ~rdVal[7];
              bitCnt_q <= 4'h1;
              state_q <= iox_pkg::ST_TX;
            end else begin
              sdaOe <= 1'b0;
              cmdPend_q <= 1'b1;
              state_q <= iox_pkg::ST_RX;
            end
          end
        end
        iox_pkg::ST_RACK: begin
          if (sclRise) begin
            cmdPend_q <= 1'b0;
          end else if (sclFall) begin
            sdaOe <= 1'b0;
            state_q <= iox_pkg::ST_RX;
          end
        end
        iox_pkg::ST_TX: begin
          if (sclFall) begin
            if (bitCnt_q == iox_pkg::BYTE_BITS) begin
              sdaOe <= 1'b0;
              state_q <= iox_pkg::ST_TACK;
            end else begin
              sdaOe <= ~tx_q[3'h7 - bitCnt_q[2:0]];
              bitCnt_q <= bitCnt_q + 4'h1;
            end
          end
        end
        iox_pkg::ST_TACK: begin
          if (sclRise) begin
            ackOk_q <= ~pinsSync.sda;
          end else if (sclFall) begin
            if (ackOk_q) begin
              tx_q <= rdVal;
              sdaOe <= ~rdVal[7];
              bitCnt_q <= 4'h1;
              state_q <= iox_pkg::ST_TX;
            end else begin
              state_q <= iox_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= iox_pkg::ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register file

  logic dataCapture;

  // Command byte and data bytes are taken at the ack clock rising edge
  assign dataCapture = (state_q == iox_pkg::ST_RACK) && sclRise && !startDet && !stopDet;

  always_ff @(posedge mclk) begin
    if (rstInt) begin
      cmd_q <= iox_pkg::RST_CMD;
      out_q <= iox_pkg::RST_OUTPUT;
      pol_q <= iox_pkg::RST_POLARITY;
      cfg_q <= iox_pkg::RST_CONFIG;
    end else if (dataCapture) begin
      if (cmdPend_q) begin
        cmd_q <= shift_q[1:0];
      end else begin
        case (cmd_q)
          iox_pkg::CMD_OUTPUT: out_q <= shift_q;
          iox_pkg::CMD_POLARITY: pol_q <= shift_q;
          iox_pkg::CMD_CONFIG: cfg_q <= shift_q;
          default: ;
        endcase
      end
    end
  end

  // Port drivers follow the registers; reset keeps every pin undriven
  always_ff @(posedge mclk) begin
    if (rstInt) begin
      portOut <= iox_pkg::RST_OUTPUT;
      portOe <= ~iox_pkg::RST_CONFIG;
    end else begin
      portOut <= out_q;
      portOe <= ~cfg_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Change alert

  logic [7:0] snap_q;
  logic [7:0] snapD;
  logic clearNow;
  logic alertD;

  // The clear point is the ack clock rise of an input port read; a change in that
  // same mclk cycle lands in the snapshot and is not flagged
  assign clearNow = (state_q == iox_pkg::ST_TACK) && sclRise && !startDet && !stopDet
                    && cmd_q == iox_pkg::CMD_INPUT;
  assign snapD = clearNow ? pinsSync.port : snap_q;
  assign alertD = |((pinsSync.port ^ snapD) & cfg_q);

  // Snapshot follows the pins while the reset pin is low, so no alert right after it; under rst it loads the synchroniser reset value 8'h00
  always_ff @(posedge mclk) begin
    if (rstInt) begin
      snap_q <= pinsSync.port;
      alertOe <= 1'b0;
      alertOutN <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      snap_q <= snapD;
      alertOe <= alertD;
      alertOutN <= 1'b0;
      sdaOut <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_reset_defaults;
    @(posedge mclk) rstInt |=> (cfg_q == 8'hff && out_q == 8'hff && pol_q == 8'h00
                                && state_q == iox_pkg::ST_IDLE && !alertOe);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("reset defaults wrong");

  property p_alert_set;
    @(posedge mclk) disable iff (rstInt) !clearNow && ((pinsSync.port ^ snap_q) & cfg_q) != 8'h00 |=> alertOe;
  endproperty
  a_alert_set: assert property (p_alert_set) else $error("alert not raised");

  property p_alert_quiet;
    @(posedge mclk) disable iff (rstInt) (((pinsSync.port ^ snap_q) & cfg_q) == 8'h00 && !clearNow)
      |=> !alertOe;
  endproperty
  a_alert_quiet: assert property (p_alert_quiet) else $error("alert without input change");

  property p_alert_clear;
    @(posedge mclk) disable iff (rstInt) clearNow |=> !alertOe ##1 (snap_q == $past(pinsSync.port, 2));
  endproperty
  a_alert_clear: assert property (p_alert_clear) else $error("read did not clear alert");

  property p_capture;
    @(posedge mclk) disable iff (rstInt) (dataCapture && !cmdPend_q && cmd_q == iox_pkg::CMD_CONFIG)
      |=> cfg_q == $past(shift_q) ##1 portOe == ~$past(shift_q, 2);
  endproperty
  a_capture: assert property (p_capture) else $error("data byte not captured");

  property p_input_readonly;
    @(posedge mclk) disable iff (rstInt) (dataCapture && !cmdPend_q && cmd_q == iox_pkg::CMD_INPUT)
      |=> $stable(out_q) && $stable(pol_q) && $stable(cfg_q);
  endproperty
  a_input_readonly: assert property (p_input_readonly) else $error("input port write took effect");

  property p_addr_match;
    @(posedge mclk) disable iff (rstInt) (state_q == iox_pkg::ST_ADDR && sclFall && !startDet
      && !stopDet && bitCnt_q == 4'h8 && shift_q[7:1] == ownAddr) |=> sdaOe && state_q == iox_pkg::ST_AACK;
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("own address not acknowledged");

  property p_other_target;
    @(posedge mclk) disable iff (rstInt) (state_q == iox_pkg::ST_ADDR && sclFall && !startDet
      && !stopDet && bitCnt_q == 4'h8 && shift_q[7:1] != ownAddr) |=> state_q == iox_pkg::ST_IDLE && !sdaOe;
  endproperty
  a_other_target: assert property (p_other_target) else $error("foreign address answered");

  property p_start_abandon;
    @(posedge mclk) disable iff (rstInt) startDet |=> state_q == iox_pkg::ST_ADDR && bitCnt_q == 4'h0 && !sdaOe;
  endproperty
  a_start_abandon: assert property (p_start_abandon) else $error("start did not restart address");

endmodule : iox_expander

/* rtl/iox_sync.sv */
/*
  Multi-bit two-stage synchroniser for asynchronous pin inputs.
  Assumes each bit is independent; no bus coherency is implied.
*/
`timescale 1ns/1ps
module iox_sync #(
  parameter int WIDTH = 12
) (
  input wire logic mclk, // System clock
  input wire logic [WIDTH-1:0] asyncIn, // Pin levels
  input wire logic [WIDTH-1:0] resetVal, // Value loaded under reset
  input wire logic rst, // Synchronous reset
  output logic [WIDTH-1:0] syncOut // Synchronised levels
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge mclk) begin
    meta_q <= asyncIn;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      syncOut <= resetVal;
    end else begin
      syncOut <= meta_q;
    end
  end

endmodule : iox_sync

/* tb/iox_ctrl_model.sv */
/*
  Two-wire bus controller model: drives SCL and pulls SDA low.
  Assumes the bench resolves SDA from all pull-downs and a pull-up.
*/
`timescale 1ns/1ps
module iox_ctrl_model (
  input wire logic mclk, // Paces the bus, 8 mclk per bit
  input wire logic sdaWire, // Resolved SDA level
  output logic scl, // Bus clock, high between frames
  output logic sdaPull // High pulls SDA low
);
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Every change lands 1 ns after an edge, never on it
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : w

  // Also serves as repeated start after an acknowledge
  task automatic start();
    w(3);
    sdaPull = 1'b0;
    w(3);
    scl = 1'b1;
    w(3);
    sdaPull = 1'b1;
    w(3);
    scl = 1'b0;
  endtask : start

  task automatic stop();
    w(2);
    sdaPull = 1'b1;
    w(3);
    scl = 1'b1;
    w(3);
    sdaPull = 1'b0;
    w(3);
  endtask : stop

  // Data moves while SCL is low; sampled late in the high phase to let the target settle
  task automatic bitx(input logic b, output logic r);
    w(2);
    sdaPull = ~b;
    w(3);
    scl = 1'b1;
    w(2);
    r = sdaWire;
    w(1);
    scl = 1'b0;
  endtask : bitx

  // MSB first; ackIn high leaves SDA released for a not-acknowledge
  task automatic xfer(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], rx[i]);
    end
    bitx(ackIn, ack);
  endtask : xfer
endmodule : iox_ctrl_model

/* tb/iox_expander_bench.sv */
/*
  Self-checking bench of the expander: registers, alert, resets and bus sequences.
  Assumes the controller model and pull-ups on SDA and on the alert line.
*/
`timescale 1ns/1ps
module i2c_io_expander_txn_irq_bench;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] dat;
    logic [7:0] want;
  } iox_row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic rstPinN = 1'b1;
  logic addrSel = 1'b0;
  logic [7:0] portIn = 8'h00;
  logic scl, sdaPull, sdaOut, sdaOe, alertOutN, alertOe, ak;
  logic [7:0] portOut, portOe, rx;
  logic [6:0] addr = 7'h20;
  int nMismatch = 0;
  int numChecks = 0;
  iox_row_t rows [4] = '{24'h01a5a5, 24'h020c0c, 24'h030f0f, 24'h007756};
  wire sdaWire = (sdaOe ? sdaOut : 1'b1) & ~sdaPull;
  wire alertWire = alertOe ? alertOutN : 1'b1;

  always #20 mclk = ~mclk;

  iox_expander i_iox_expander (.mclk(mclk), .rst(rst), .rstPinN(rstPinN), .addrSel(addrSel), .scl(scl),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .portIn(portIn), .portOut(portOut), .portOe(portOe),
    .alertOutN(alertOutN), .alertOe(alertOe));
  iox_ctrl_model i_iox_ctrl_model (.mclk(mclk), .sdaWire(sdaWire), .scl(scl), .sdaPull(sdaPull));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    numChecks++;
    if (g !== e) begin
      nMismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic conclude();
    if (nMismatch == 0 && numChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  // Acknowledge bit seen by the controller: 0 acked, 1 released
  task automatic put(input logic [7:0] b, input logic e);
    i_iox_ctrl_model.xfer(b, 1'b1, rx, ak);
    chk("ack", {7'h0, e}, {7'h0, ak});
  endtask : put

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    i_iox_ctrl_model.start();
    put({addr, 1'b0}, 1'b0);
    put(cmd, 1'b0);
    put(d, 1'b0);
    i_iox_ctrl_model.stop();
  endtask : wr

  task automatic rd(input logic [7:0] cmd, input logic [7:0] e);
    i_iox_ctrl_model.start();
    put({addr, 1'b0}, 1'b0);
    put(cmd, 1'b0);
    i_iox_ctrl_model.start();
    put({addr, 1'b1}, 1'b0);
    i_iox_ctrl_model.xfer(8'hff, 1'b1, rx, ak);
    i_iox_ctrl_model.stop();
    chk("read", e, rx);
  endtask : rd

  task automatic nak(input logic [6:0] a);
    i_iox_ctrl_model.start();
    put({a, 1'b0}, 1'b1);
    i_iox_ctrl_model.stop();
  endtask : nak

  // Pipeline is 3 mclk from a pin edge, so 4 leaves margin
  task automatic pin(input logic [7:0] v, input logic e);
    portIn = v;
    i_iox_ctrl_model.w(4);
    chk("alert", {7'h0, e}, {7'h0, alertWire});
  endtask : pin

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge mclk);
    nMismatch++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge mclk);
    #1;
    rst = 1'b0;
    i_iox_ctrl_model.w(4);
    chk("portOut", iox_pkg::RST_OUTPUT, portOut);
    chk("portOe", 8'h00, portOe);
    rd(8'h01, iox_pkg::RST_OUTPUT);
    rd(8'h02, iox_pkg::RST_POLARITY);
    rd(8'h03, iox_pkg::RST_CONFIG);
    portIn = 8'h5a;
    foreach (rows[i]) begin
      wr(rows[i].cmd, rows[i].dat);
      rd(rows[i].cmd, rows[i].want);
    end
    chk("portOut", 8'ha5, portOut);
    chk("portOe", 8'hf0, portOe);
    i_iox_ctrl_model.start();
    put({addr, 1'b0}, 1'b0);
    put(8'h01, 1'b0);
    for (int i = 1; i < 4; i++) begin
      put(8'h11 * i[7:0], 1'b0);
    end
    repeat (4) i_iox_ctrl_model.bitx(1'b0, ak);
    i_iox_ctrl_model.stop();
    chk("portOut", 8'h33, portOut);
    pin(8'hda, 1'b1);
    pin(8'hdb, 1'b0);
    pin(8'hda, 1'b1);
    pin(8'hd8, 1'b0);
    nak(7'h21);
    chk("alert", 8'h00, {7'h0, alertWire});
    rd(8'h00, 8'hd4);
    chk("alert", 8'h01, {7'h0, alertWire});
    pin(8'hd9, 1'b0);
    i_iox_ctrl_model.start();
    put({addr, 1'b1}, 1'b0);
    fork
      i_iox_ctrl_model.xfer(8'hff, 1'b0, rx, ak);
      begin
        i_iox_ctrl_model.w(30);
        portIn = 8'hd6;
      end
    join
    chk("direct", 8'hd5, rx);
    i_iox_ctrl_model.xfer(8'hff, 1'b1, rx, ak);
    i_iox_ctrl_model.stop();
    chk("direct", 8'hda, rx);
    chk("alert", 8'h01, {7'h0, alertWire});
    addrSel = 1'b1;
    addr = 7'h21;
    nak(7'h20);
    wr(8'h01, 8'h00);
    chk("portOut", 8'h00, portOut);
    rstPinN = 1'b0;
    i_iox_ctrl_model.w(4);
    chk("portOut", iox_pkg::RST_OUTPUT, portOut);
    nak(addr);
    chk("portOe", 8'h00, portOe);
    rstPinN = 1'b1;
    i_iox_ctrl_model.w(5);
    chk("alert", 8'h01, {7'h0, alertWire});
    rd(8'h03, iox_pkg::RST_CONFIG);
    chk("portOut", iox_pkg::RST_OUTPUT, portOut);
    conclude();
  end
endmodule : i2c_io_expander_txn_irq_bench
